// ### bsctp_defines.svh
// Constants of the boundary scan test port: widths, codes, cell positions
`ifndef BSCTP_DEFINES_SVH
`define BSCTP_DEFINES_SVH

// ----------------------------------------
// Register sizes
// ----------------------------------------
`define BSCTP_IR_WIDTH 3
`define BSCTP_BSR_LEN 133
`define BSCTP_CTL_COUNT 24

// ----------------------------------------
// Instruction codes and reset values
// ----------------------------------------
`define BSCTP_CODE_EXTEST 3'h0
`define BSCTP_CODE_SAMPLE 3'h1
`define BSCTP_CODE_OFF 3'h4
`define BSCTP_IR_RESET 3'h7
`define BSCTP_IR_CAPTURE_LOW 2'h1
`define BSCTP_BYPASS_CAPTURE 1'h0

// ----------------------------------------
// Output enable cell positions, index 0 in the low byte
// ----------------------------------------
`define BSCTP_CTL_POSITIONS {8'h83, 8'h7E, 8'h7B, 8'h66, 8'h64, 8'h62, 8'h60, 8'h5E, \
   8'h5C, 8'h5A, 8'h58, 8'h56, 8'h55, 8'h54, 8'h53, 8'h42, 8'h40, 8'h3E, 8'h3C, \
   8'h3A, 8'h38, 8'h36, 8'h34, 8'h1D}
// Enable cells that turn drivers on with a one
`define BSCTP_CTL_ACTIVE_HIGH 24'h80_1601

`endif

// ### bsctp_pkg.sv
// Types and decode helpers of the boundary scan test port
`default_nettype none
`include "bsctp_defines.svh"

package bsctp_pkg;

   // ----------------------------------------
   // Controller states and decoded instructions
   // ----------------------------------------
   typedef enum logic [3:0] {
      TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR, TAP_PAU_DR,
      TAP_EX2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR, TAP_EX1_IR,
      TAP_PAU_IR, TAP_EX2_IR, TAP_UPD_IR
   } bsctp_tap_state_e;

   typedef enum logic [1:0] {
      INSTR_EXTEST, INSTR_SAMPLE, INSTR_BYPASS, INSTR_OFF
   } bsctp_instr_e;

   // Instruction code to operation
   function automatic bsctp_instr_e decode_instr(input logic [2:0] code);
      bsctp_instr_e res;
      res = INSTR_BYPASS;
      if (code[1]) begin
         res = INSTR_BYPASS;
      end else if (code == `BSCTP_CODE_EXTEST) begin
         res = INSTR_EXTEST;
      end else if (code == `BSCTP_CODE_SAMPLE) begin
         res = INSTR_SAMPLE;
      end else if (code == `BSCTP_CODE_OFF) begin
         res = INSTR_OFF;
      end
      return res;
   endfunction

   // Position of an output enable cell by its index
   function automatic logic [7:0] ctl_pos(input int unsigned idx);
      logic [191:0] all;
      all = `BSCTP_CTL_POSITIONS;
      return all[idx*8 +: 8];
   endfunction

   // True where a boundary position is an output enable cell
   function automatic logic is_ctl_cell(input int unsigned pos);
      logic hit;
      hit = 1'h0;
      for (int unsigned i = 0; i < `BSCTP_CTL_COUNT; i++) begin
         if (32'(ctl_pos(i)) == pos) begin
            hit = 1'h1;
         end
      end
      return hit;
   endfunction

endpackage

`default_nettype wire

// ### bsctp_sync.sv
// Two-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none

module bsctp_sync #(
   parameter int WIDTH = 1
) (
   // Destination clock
   input wire logic clk,
   // Level from the other domain
   input wire logic [WIDTH-1:0] async_in,
   // Level in the destination domain
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   // First stage read only by second stage
   always_ff @(posedge clk) begin
      meta_q <= async_in;
      sync_q <= meta_q;
   end

   assign sync_out = sync_q;

endmodule // bsctp_sync

`default_nettype wire

// ### bsctp_top.sv
// Test access port controller with instruction, bypass and boundary registers
`timescale 1ns/1ps
`default_nettype none
`include "bsctp_defines.svh"

// Function
// - Sixteen-state controller, two data registers, logic apart from system logic.
// - Mode select and data input sampled on rising test clock; pins pulled up.
// - Data output driven only in shift states, changing on falling edge.
// - Three-bit instruction shifter; outputs copied only in update-IR.
// - Test-logic-reset presets instruction outputs to all ones, meaning bypass.
// - Decode: 000 external test, 001 sample, x1x bypass, 100 off, 101 bypass.
// - Capture-IR loads fixed pattern low and crystal-lost flag into bit two.
// - Crystal-lost flag is one only without clock on crystal source.
// - External test puts 133-bit boundary register between data input and output.
// - Oscillator and filter pins have no boundary cells.
// - External test holds system logic in reset.
// - External test drives outputs, captures inputs, sets directions and enables.
// - One data cell per bidirectional pin; done pins two control cells.
// - Twenty-four enable cells at the listed positions.
// - Active-high enable cell enables on one; active-low on zero.
// - Position zero nearest data output, shifted first; 132 shifted last.
// - Outputs-off instruction turns every output driver off.
// - Bypass path is one single-bit register.
// - Bypass stage loads zero in capture-DR.
// - Sample snapshots pins in capture-DR; shifted values preset output cells.
// - Outputs-off instruction selects the bypass register.
// - Power-on reset holds controller in test-logic-reset, ignoring commands.
module bsctp_top (
   // System clock and power-on reset
   input wire logic clk,
   input wire logic srst,
   // Test access port
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   output logic tdo,
   output logic tdo_oe,
   // Clock status from the oscillator block
   input wire logic crystal_lost_flag,
   input wire logic ext_clock_mode,
   // Pad ring side of the boundary cells
   input wire logic [`BSCTP_BSR_LEN-1:0] pin_level,
   output logic [`BSCTP_BSR_LEN-1:0] cell_value,
   output logic [`BSCTP_CTL_COUNT-1:0] group_oe,
   output logic boundary_drive,
   output logic outputs_off,
   // System side controls
   output logic core_reset,
   output logic tap_in_reset
);

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   bsctp_pkg::bsctp_tap_state_e state_q;
   bsctp_pkg::bsctp_tap_state_e state_d;
   bsctp_pkg::bsctp_instr_e instr;
   logic por_tck;
   logic loc_q;
   logic loc_tck;
   logic extest_clk;
   logic core_reset_q;
   logic [`BSCTP_IR_WIDTH-1:0] ir_sh_q;
   logic [`BSCTP_IR_WIDTH-1:0] ir_q;
   logic bypass_q;
   logic [`BSCTP_BSR_LEN-1:0] pin_tck;
   logic [`BSCTP_BSR_LEN-1:0] bsr_sh_q;
   logic [`BSCTP_BSR_LEN-1:0] bsr_upd_q;
   logic [`BSCTP_BSR_LEN-1:0] ctl_mask;
   logic [`BSCTP_CTL_COUNT-1:0] group_oe_q;
   logic [`BSCTP_CTL_COUNT-1:0] group_oe_d;
   logic boundary_drive_q;
   logic outputs_off_q;
   logic tap_in_reset_q;
   logic tdo_q;
   logic tdo_oe_q;
   logic bsr_sel;
   // Polarity of each enable cell, one where a one turns drivers on
   localparam logic [`BSCTP_CTL_COUNT-1:0] CTL_HIGH = `BSCTP_CTL_ACTIVE_HIGH;

   // ----------------------------------------
   // Crossings between system clock and test clock
   // ----------------------------------------

   // Power-on reset into the test clock domain
   bsctp_sync #(.WIDTH(1)) u_por_sync (
      .clk(tck),
      .async_in(srst),
      .sync_out(por_tck)
   );

   // Crystal-lost level, forced clear with external clock
   always_ff @(posedge clk) begin
      if (srst) begin
         loc_q <= 1'h0;
      end else begin
         loc_q <= crystal_lost_flag & ~ext_clock_mode;
      end
   end

   bsctp_sync #(.WIDTH(1)) u_loc_sync (
      .clk(tck),
      .async_in(loc_q),
      .sync_out(loc_tck)
   );

   // Pin levels sampled into the test clock domain
   bsctp_sync #(.WIDTH(`BSCTP_BSR_LEN)) u_pin_sync (
      .clk(tck),
      .async_in(pin_level),
      .sync_out(pin_tck)
   );

   // External test level back into the system domain
   bsctp_sync #(.WIDTH(1)) u_ext_sync (
      .clk(clk),
      .async_in(boundary_drive_q),
      .sync_out(extest_clk)
   );

   // Core held in reset while external test runs
   always_ff @(posedge clk) begin
      if (srst) begin
         core_reset_q <= 1'h1;
      end else begin
         core_reset_q <= extest_clk;
      end
   end

   // ----------------------------------------
   // Controller state machine
   // ----------------------------------------

   // Next state from mode select
   always_comb begin
      state_d = state_q;
      case (state_q)
         bsctp_pkg::TAP_RESET: begin
            state_d = tms ? bsctp_pkg::TAP_RESET : bsctp_pkg::TAP_IDLE;
         end
         bsctp_pkg::TAP_IDLE: begin
            state_d = tms ? bsctp_pkg::TAP_SEL_DR : bsctp_pkg::TAP_IDLE;
         end
         bsctp_pkg::TAP_SEL_DR: begin
            state_d = tms ? bsctp_pkg::TAP_SEL_IR : bsctp_pkg::TAP_CAP_DR;
         end
         bsctp_pkg::TAP_CAP_DR: begin
            state_d = tms ? bsctp_pkg::TAP_EX1_DR : bsctp_pkg::TAP_SH_DR;
         end
         bsctp_pkg::TAP_SH_DR: begin
            state_d = tms ? bsctp_pkg::TAP_EX1_DR : bsctp_pkg::TAP_SH_DR;
         end
         bsctp_pkg::TAP_EX1_DR: begin
            state_d = tms ? bsctp_pkg::TAP_UPD_DR : bsctp_pkg::TAP_PAU_DR;
         end
         bsctp_pkg::TAP_PAU_DR: begin
            state_d = tms ? bsctp_pkg::TAP_EX2_DR : bsctp_pkg::TAP_PAU_DR;
         end
         bsctp_pkg::TAP_EX2_DR: begin
            state_d = tms ? bsctp_pkg::TAP_UPD_DR : bsctp_pkg::TAP_SH_DR;
         end
         bsctp_pkg::TAP_UPD_DR: begin
            state_d = tms ? bsctp_pkg::TAP_SEL_DR : bsctp_pkg::TAP_IDLE;
         end
         bsctp_pkg::TAP_SEL_IR: begin
            state_d = tms ? bsctp_pkg::TAP_RESET : bsctp_pkg::TAP_CAP_IR;
         end
         bsctp_pkg::TAP_CAP_IR: begin
            state_d = tms ? bsctp_pkg::TAP_EX1_IR : bsctp_pkg::TAP_SH_IR;
         end
         bsctp_pkg::TAP_SH_IR: begin
            state_d = tms ? bsctp_pkg::TAP_EX1_IR : bsctp_pkg::TAP_SH_IR;
         end
         bsctp_pkg::TAP_EX1_IR: begin
            state_d = tms ? bsctp_pkg::TAP_UPD_IR : bsctp_pkg::TAP_PAU_IR;
         end
         bsctp_pkg::TAP_PAU_IR: begin
            state_d = tms ? bsctp_pkg::TAP_EX2_IR : bsctp_pkg::TAP_PAU_IR;
         end
         bsctp_pkg::TAP_EX2_IR: begin
            state_d = tms ? bsctp_pkg::TAP_UPD_IR : bsctp_pkg::TAP_SH_IR;
         end
         bsctp_pkg::TAP_UPD_IR: begin
            state_d = tms ? bsctp_pkg::TAP_SEL_DR : bsctp_pkg::TAP_IDLE;
         end
         default: begin
            state_d = bsctp_pkg::TAP_RESET;
         end
      endcase
   end

   // State register, held in reset during power-on
   always_ff @(posedge tck) begin
      if (por_tck) begin
         state_q <= bsctp_pkg::TAP_RESET;
      end else begin
         state_q <= state_d;
      end
   end

   // ----------------------------------------
   // Instruction register
   // ----------------------------------------

   // Instruction shifter: capture, shift toward data output
   always_ff @(posedge tck) begin
      if (por_tck) begin
         ir_sh_q <= `BSCTP_IR_RESET;
      end else if (state_q == bsctp_pkg::TAP_CAP_IR) begin
         ir_sh_q <= {loc_tck, `BSCTP_IR_CAPTURE_LOW};
      end else if (state_q == bsctp_pkg::TAP_SH_IR) begin
         ir_sh_q <= {tdi, ir_sh_q[`BSCTP_IR_WIDTH-1:1]};
      end
   end

   // Parallel outputs, loaded in update-IR, preset to all ones in test-logic-reset
   always_ff @(posedge tck) begin
      if (por_tck || state_q == bsctp_pkg::TAP_RESET) begin
         ir_q <= `BSCTP_IR_RESET;
      end else if (state_q == bsctp_pkg::TAP_UPD_IR) begin
         ir_q <= ir_sh_q;
      end
   end

   // Current operation
   assign instr = bsctp_pkg::decode_instr(ir_q);

   // Boundary path for external test and sample, bypass otherwise
   assign bsr_sel = (instr == bsctp_pkg::INSTR_EXTEST) ||
                    (instr == bsctp_pkg::INSTR_SAMPLE);

   // ----------------------------------------
   // Bypass register
   // ----------------------------------------

   // Single stage, zero on capture
   always_ff @(posedge tck) begin
      if (por_tck) begin
         bypass_q <= `BSCTP_BYPASS_CAPTURE;
      end else if (!bsr_sel && state_q == bsctp_pkg::TAP_CAP_DR) begin
         bypass_q <= `BSCTP_BYPASS_CAPTURE;
      end else if (!bsr_sel && state_q == bsctp_pkg::TAP_SH_DR) begin
         bypass_q <= tdi;
      end
   end

   // ----------------------------------------
   // Boundary scan register
   // ----------------------------------------

   // Which positions hold enable cells
   always_comb begin
      ctl_mask = '0;
      for (int unsigned p = 0; p < `BSCTP_BSR_LEN; p++) begin
         ctl_mask[p] = bsctp_pkg::is_ctl_cell(p);
      end
   end

   // Shift stage: enable cells capture their own latch, others the pin
   always_ff @(posedge tck) begin
      if (por_tck) begin
         bsr_sh_q <= '0;
      end else if (bsr_sel && state_q == bsctp_pkg::TAP_CAP_DR) begin
         bsr_sh_q <= (pin_tck & ~ctl_mask) | (bsr_upd_q & ctl_mask);
      end else if (bsr_sel && state_q == bsctp_pkg::TAP_SH_DR) begin
         bsr_sh_q <= {tdi, bsr_sh_q[`BSCTP_BSR_LEN-1:1]};
      end
   end

   // Update latch, presets output cells under sample
   always_ff @(posedge tck) begin
      if (por_tck) begin
         bsr_upd_q <= '0;
      end else if (bsr_sel && state_q == bsctp_pkg::TAP_UPD_DR) begin
         bsr_upd_q <= bsr_sh_q;
      end
   end

   // ----------------------------------------
   // Pad controls
   // ----------------------------------------

   // Group enables from enable cells with their polarity
   always_comb begin
      group_oe_d = '0;
      for (int unsigned i = 0; i < `BSCTP_CTL_COUNT; i++) begin
         group_oe_d[i] = (instr == bsctp_pkg::INSTR_EXTEST) &&
            (bsr_upd_q[bsctp_pkg::ctl_pos(i)] == CTL_HIGH[i]);
      end
   end

   // Pad control flops
   always_ff @(posedge tck) begin
      if (por_tck) begin
         group_oe_q <= '0;
         boundary_drive_q <= 1'h0;
         outputs_off_q <= 1'h0;
         tap_in_reset_q <= 1'h1;
      end else begin
         group_oe_q <= group_oe_d;
         boundary_drive_q <= (instr == bsctp_pkg::INSTR_EXTEST);
         outputs_off_q <= (instr == bsctp_pkg::INSTR_OFF);
         tap_in_reset_q <= (state_q == bsctp_pkg::TAP_RESET);
      end
   end

   // ----------------------------------------
   // Test data output
   // ----------------------------------------

   // Falling edge output, driven only while shifting
   always_ff @(negedge tck) begin
      if (por_tck) begin
         tdo_q <= 1'h0;
         tdo_oe_q <= 1'h0;
      end else begin
         tdo_oe_q <= (state_q == bsctp_pkg::TAP_SH_IR) ||
                     (state_q == bsctp_pkg::TAP_SH_DR);
         if (state_q == bsctp_pkg::TAP_SH_IR) begin
            tdo_q <= ir_sh_q[0];
         end else if (state_q == bsctp_pkg::TAP_SH_DR) begin
            tdo_q <= bsr_sel ? bsr_sh_q[0] : bypass_q;
         end
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign tdo = tdo_q;
   assign tdo_oe = tdo_oe_q;
   assign cell_value = bsr_upd_q;
   assign group_oe = group_oe_q;
   assign boundary_drive = boundary_drive_q;
   assign outputs_off = outputs_off_q;
   assign core_reset = core_reset_q;
   assign tap_in_reset = tap_in_reset_q;

endmodule // bsctp_top

`default_nettype wire

// ### bsctp_top_sva.sv
// Concurrent checks on the ports of the boundary scan test port
`timescale 1ns/1ps
`default_nettype none
`include "bsctp_defines.svh"

module bsctp_top_sva (
   // Clocks and reset
   input wire logic clk,
   input wire logic srst,
   input wire logic tck,
   // Test access port
   input wire logic tms,
   input wire logic tdi,
   input wire logic tdo,
   input wire logic tdo_oe,
   // Clock status
   input wire logic crystal_lost_flag,
   input wire logic ext_clock_mode,
   // Pad and system side
   input wire logic [`BSCTP_BSR_LEN-1:0] pin_level,
   input wire logic [`BSCTP_BSR_LEN-1:0] cell_value,
   input wire logic [`BSCTP_CTL_COUNT-1:0] group_oe,
   input wire logic boundary_drive,
   input wire logic outputs_off,
   input wire logic core_reset,
   input wire logic tap_in_reset
);
   // ----------------------------------------
   // Sequences
   // ----------------------------------------
   sequence five_high_s;
      tms [*5];
   endsequence
   sequence extest_held_s;
      boundary_drive [*4];
   endsequence

   // ----------------------------------------
   // Test clock domain
   // ----------------------------------------
   a_drive_exclusive: assert property (@(posedge tck) disable iff (srst)
      !(boundary_drive && outputs_off)) else $error("extest and outputs off both active");
   a_oe_gated: assert property (@(posedge tck) disable iff (srst)
      (group_oe != '0) |-> boundary_drive || $past(boundary_drive))
      else $error("group enable outside extest");
   a_off_no_oe: assert property (@(posedge tck) disable iff (srst)
      outputs_off && $past(outputs_off) |-> group_oe == '0)
      else $error("driver enabled under outputs off");
   a_five_reset: assert property (@(posedge tck) disable iff (srst)
      five_high_s |-> ##[1:2] tap_in_reset) else $error("five high mode cycles missed reset");
   a_tlr_quiet: assert property (@(posedge tck) disable iff (srst)
      tap_in_reset |-> !tdo_oe) else $error("data output driven in reset state");
   a_tlr_bypass: assert property (@(posedge tck) disable iff (srst)
      tap_in_reset [*3] |-> !boundary_drive && !outputs_off && group_oe == '0)
      else $error("reset state not bypass");

   // ----------------------------------------
   // System clock domain
   // ----------------------------------------
   a_core_on: assert property (@(posedge clk) disable iff (srst)
      extest_held_s |-> core_reset) else $error("core not held under extest");
   a_core_off: assert property (@(posedge clk) disable iff (srst)
      !boundary_drive [*4] |-> !core_reset) else $error("core held without extest");
   a_core_por: assert property (@(posedge clk) srst |=> core_reset)
      else $error("core not held during power-on reset");
endmodule // bsctp_top_sva

bind bsctp_top bsctp_top_sva bsctp_top_sva_i (.clk, .srst, .tck, .tms, .tdi, .tdo, .tdo_oe,
   .crystal_lost_flag, .ext_clock_mode, .pin_level, .cell_value, .group_oe, .boundary_drive,
   .outputs_off, .core_reset, .tap_in_reset);
`default_nettype wire

// ### bsctp_tester.sv
// Board test controller model driving the test access port
`timescale 1ns/1ps
`default_nettype none

module bsctp_tester (
   // Driven lines
   output logic tck,
   output logic tms,
   output logic tdi,
   // Observed lines
   input wire logic tdo,
   input wire logic tdo_oe
);
   // Clock parked low, lines at pull-up level until first frame
   initial begin
      tck = 1'h0;
      tms = 1'h1;
      tdi = 1'h1;
   end

   // One test clock period; data out read at the rising edge, released reads as z
   task automatic step(input logic m, input logic d, output logic o);
      tms = m;
      tdi = d;
      #40;
      tck = 1'h1;
      o = tdo_oe ? tdo : 1'hz;
      #40;
      tck = 1'h0;
   endtask
endmodule // bsctp_tester
`default_nettype wire

// ### test_boundary_scan_test_port.sv
// Self-checking testbench of the boundary scan test port
`timescale 1ns/1ps
`default_nettype none
`include "bsctp_defines.svh"

module test_boundary_scan_test_port;
   // ----------------------------------------
   // Constants and signals
   // ----------------------------------------
   localparam logic [191:0] CTL_POS = `BSCTP_CTL_POSITIONS;
   localparam logic [23:0] CTL_HI = `BSCTP_CTL_ACTIVE_HIGH;
   localparam logic [132:0] PRE = {7{19'h2_A3C6}};
   logic clk, srst, tck, tms, tdi, tdo, tdo_oe, crystal_lost_flag, ext_clock_mode;
   logic [132:0] pin_level = {7{19'h6_1B39}};
   logic [132:0] cell_value, mask;
   logic [23:0] group_oe;
   logic boundary_drive, outputs_off, core_reset, tap_in_reset;
   int error_cnt = 0;
   int checked = 0;
   int cycles = 0;

   bsctp_top bsctp_top_i (.clk, .srst, .tck, .tms, .tdi, .tdo, .tdo_oe, .crystal_lost_flag,
      .ext_clock_mode, .pin_level, .cell_value, .group_oe, .boundary_drive, .outputs_off,
      .core_reset, .tap_in_reset);
   bsctp_tester bsctp_tester_i (.tck, .tms, .tdi, .tdo, .tdo_oe);

   // System clock and hang limit
   initial begin
      clk = 1'h0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         error_cnt++;
         give_verdict();
      end
   end

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic give_verdict();
      if (error_cnt == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [132:0] e, input logic [132:0] g);
      checked++;
      if (g !== e) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   function automatic logic [23:0] oe_of(input logic [132:0] v);
      for (int i = 0; i < 24; i++) oe_of[i] = v[CTL_POS[i*8 +: 8]] ~^ CTL_HI[i];
   endfunction
   task automatic stp(input logic m, input logic d);
      logic o;
      bsctp_tester_i.step(m, d, o);
   endtask
   task automatic ir_scan(input logic [2:0] code, output logic [2:0] c);
      logic o;
      stp(1'h1, 1'h1);
      stp(1'h1, 1'h1);
      stp(1'h0, 1'h1);
      stp(1'h0, 1'h1);
      for (int i = 0; i < 3; i++) begin
         bsctp_tester_i.step(i == 2, code[i], o);
         c[i] = o;
      end
      stp(1'h1, 1'h1);
      stp(1'h0, 1'h1);
      stp(1'h0, 1'h1);
   endtask
   task automatic dr_scan(input int n, input logic [132:0] d, output logic [132:0] q);
      logic o;
      q = '0;
      stp(1'h1, 1'h1);
      stp(1'h0, 1'h1);
      stp(1'h0, 1'h1);
      for (int i = 0; i < n; i++) begin
         bsctp_tester_i.step(i == n - 1, d[i], o);
         q[i] = o;
      end
      stp(1'h1, 1'h1);
      stp(1'h0, 1'h1);
      stp(1'h0, 1'h1);
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset();
      logic o;
      fork
         begin repeat (12) @(posedge clk); #1 srst = 1'h0; end
         begin #7; repeat (3) stp(1'h0, 1'h1); end
      join
      repeat (2) stp(1'h0, 1'h1);
      chk("in_reset", 133'(1'h1), 133'(tap_in_reset));
      repeat (6) stp(1'h1, 1'h1);
      stp(1'h0, 1'h1);
      chk("idle_enables", '0, 133'({boundary_drive, outputs_off, core_reset, group_oe}));
      bsctp_tester_i.step(1'h0, 1'h1, o);
      chk("tdo_idle", 133'(1'hz), 133'(o));
   endtask
   task automatic t_bypass();
      logic [2:0] codes [6] = '{3'h7, 3'h2, 3'h3, 3'h6, 3'h5, 3'h4};
      logic [132:0] q;
      logic [2:0] c;
      dr_scan(4, 133'hB, q);
      chk("bypass_reset", 133'h6, q);
      for (int i = 0; i < 6; i++) begin
         ir_scan(codes[i], c);
         dr_scan(4, 133'hB, q);
         chk("bypass", 133'h6, q);
         chk("off", 133'(codes[i] == 3'h4), 133'(outputs_off));
         chk("drive", '0, 133'(boundary_drive));
      end
   endtask
   task automatic t_capture();
      logic [2:0] c;
      for (int i = 0; i < 3; i++) begin
         @(posedge clk);
         #1 crystal_lost_flag = (i != 2);
         ext_clock_mode = (i == 1);
         ir_scan(3'h7, c);
         chk("capture", 133'({crystal_lost_flag & ~ext_clock_mode, 2'h1}), 133'(c));
      end
   endtask
   task automatic t_sample_extest();
      logic [132:0] q;
      logic [2:0] c;
      ir_scan(3'h1, c);
      dr_scan(133, PRE, q);
      chk("sample", pin_level & ~mask, q);
      chk("preload", PRE, cell_value);
      chk("oe_sample", '0, 133'(group_oe));
      ir_scan(3'h0, c);
      repeat (4) @(posedge clk);
      #1;
      chk("core_reset", 133'(1'h1), 133'(core_reset));
      chk("enables", 133'(oe_of(PRE)), 133'(group_oe));
      dr_scan(133, ~PRE, q);
      chk("extest_cap", (pin_level & ~mask) | (PRE & mask), q);
      chk("drive_val", ~PRE, cell_value);
      chk("enables2", 133'(oe_of(~PRE)), 133'(group_oe));
      ir_scan(3'h4, c);
      repeat (4) @(posedge clk);
      #1;
      chk("off_state", 133'h400_0000,
         133'({outputs_off, boundary_drive, core_reset, group_oe}));
      stp(1'h1, 1'h1);
      stp(1'h0, 1'h1);
      stp(1'h0, 1'h1);
      // Five highs reach reset, two more let the lagging pad flags follow
      repeat (7) stp(1'h1, 1'h1);
      chk("five_reset", 133'h2, 133'({tap_in_reset, outputs_off}));
   endtask

   // Main sequence
   initial begin
      srst = 1'h1;
      crystal_lost_flag = 1'h0;
      ext_clock_mode = 1'h0;
      mask = '0;
      for (int i = 0; i < 24; i++) mask[CTL_POS[i*8 +: 8]] = 1'h1;
      t_reset();
      t_bypass();
      t_capture();
      t_sample_extest();
      give_verdict();
   end
endmodule // test_boundary_scan_test_port
`default_nettype wire
